// file: rtl/vic_pkg.sv
// Purpose: Shared constants and types of the vectored interrupt collector
// Assumes: Classic Wishbone slave, 32-bit data, word aligned registers
// Notes: Offsets are byte addresses
package vic_pkg;

    localparam int VIC_NSRC = 64;
    localparam int VIC_PRIO_W = 4;
    localparam int VIC_IDX_W = 6;
    localparam int VIC_ADDR_W = 8;

    // ************************************************
    // Register offsets
    // ************************************************
    localparam logic [7:0] VIC_CTRL_OFF = 8'h00;
    localparam logic [7:0] VIC_ENLO_OFF = 8'h04;
    localparam logic [7:0] VIC_ENHI_OFF = 8'h08;
    localparam logic [7:0] VIC_CLSLO_OFF = 8'h0c;
    localparam logic [7:0] VIC_CLSHI_OFF = 8'h10;
    localparam logic [7:0] VIC_FRCLO_OFF = 8'h14;
    localparam logic [7:0] VIC_FRCHI_OFF = 8'h18;
    localparam logic [7:0] VIC_NPLO_OFF = 8'h1c;
    localparam logic [7:0] VIC_NPHI_OFF = 8'h20;
    localparam logic [7:0] VIC_FPLO_OFF = 8'h24;
    localparam logic [7:0] VIC_FPHI_OFF = 8'h28;
    localparam logic [7:0] VIC_VEC_OFF = 8'h2c;
    localparam logic [7:0] VIC_ISTAT_OFF = 8'h30;
    localparam logic [7:0] VIC_IMASK_OFF = 8'h34;
    localparam logic [7:0] VIC_PRIO_OFF = 8'h40;
    localparam logic [7:0] VIC_PRIO_END = 8'h60;

    // ************************************************
    // Control fields and reset values
    // ************************************************
    localparam int VIC_CTRL_NDIS_BIT = 0;
    localparam int VIC_CTRL_FDIS_BIT = 1;
    localparam int VIC_CTRL_PMASK_LSB = 4;
    localparam int VIC_VEC_VALID_BIT = 31;
    localparam logic [31:0] VIC_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] VIC_RD_NONE = 32'h0000_0000;
    localparam logic [3:0] VIC_PMASK_NONE = 4'hf;

    // Status events: bit 0 normal request rose, bit 1 fast request rose
    localparam int VIC_EV_W = 2;

    typedef struct packed {
        logic norm_dis;
        logic fast_dis;
        logic [VIC_PRIO_W-1:0] prio_mask;
    } vic_ctrl_t;

    typedef struct packed {
        logic valid;
        logic [VIC_IDX_W-1:0] idx;
        logic [VIC_PRIO_W-1:0] level;
    } vic_pick_t;

endpackage : vic_pkg

// file: rtl/vic_prio_pick.sv
// Purpose: Highest-priority pending normal source finder
// Assumes: Pending vector already gated by enable and class
// Notes: Pure combinational scan, ties go to the higher number
`timescale 1ns/1ps
module vic_prio_pick
    import vic_pkg::*;
#(
    parameter int NSRC = VIC_NSRC
)
(
    input wire logic [NSRC-1:0] pend_i,
    input wire logic [NSRC*VIC_PRIO_W-1:0] prio_i,
    output vic_pick_t pick_o
);

    always_comb
    begin
        pick_o = '0;
        // Ascending scan with >= lets a later equal level win
        for (int i = 0; i < NSRC; i++)
        begin
            if (pend_i[i] && (!pick_o.valid ||
                prio_i[i*VIC_PRIO_W +: VIC_PRIO_W] >= pick_o.level))
            begin
                pick_o.valid = 1'b1;
                pick_o.idx = VIC_IDX_W'(i);
                pick_o.level = prio_i[i*VIC_PRIO_W +: VIC_PRIO_W];
            end
        end
    end

endmodule : vic_prio_pick

// file: rtl/vic_top.sv
// Purpose: Vectored interrupt collector for a processor core
// Assumes: Classic Wishbone register access, one clock, sync reset
// Notes: Pending views are registered one cycle behind the inputs
//
// What this block does
// - Collect requests from up to 64 sources into requests toward the core.
// - Offer a 32-bit register interface to software.
// - Route each source to the normal or the fast request by a software bit.
// - Show pending sources separately for the normal and the fast class.
// - Report the highest-priority pending normal source number usable as a table index.
// - Give each source an enable so that a disabled source never requests.
// - Let software force a source, treated like a hardware request.
// - Give normal sources one of 16 levels and drop those not above the mask level.
// - Block all normal or all fast requests with one bit each.
`timescale 1ns/1ps
module vic_top
    import vic_pkg::*;
#(
    parameter int NSRC = VIC_NSRC
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [VIC_ADDR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [NSRC-1:0] src_i,
    output logic norm_irq_o,
    output logic fast_irq_o,
    output logic irq_o
);

    // ************************************************
    // Register state
    // ************************************************
    vic_ctrl_t ctrl_reg;
    logic [63:0] en_reg;
    logic [63:0] cls_reg;
    logic [63:0] frc_reg;
    logic [63:0] prio_reg [4];
    logic [63:0] npend_reg;
    logic [63:0] fpend_reg;
    vic_pick_t vec_reg;
    logic norm_reg;
    logic fast_reg;
    logic [VIC_EV_W-1:0] istat_reg;
    logic [VIC_EV_W-1:0] istat_next;
    logic [VIC_EV_W-1:0] imask_reg;

    logic wr_stb;
    logic rd_stb;
    logic [VIC_ADDR_W-1:0] acc_adr;
    logic [31:0] rd_data;

    vic_wb_slave u_wb
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cyc_i(cyc_i),
        .stb_i(stb_i),
        .we_i(we_i),
        .adr_i(adr_i),
        .rd_data_i(rd_data),
        .ack_o(ack_o),
        .dat_o(dat_o),
        .wr_stb_o(wr_stb),
        .rd_stb_o(rd_stb),
        .acc_adr_o(acc_adr)
    );

    // Byte-lane merge for writes
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
            if (sel[b])
                r[b*8 +: 8] = new_v[b*8 +: 8];
        return r;
    endfunction : lane_merge

    // Reset and writes share one field layout, so they cannot drift apart
    function automatic vic_ctrl_t ctrl_unpack(input logic [31:0] word);
        vic_ctrl_t c;
        c.norm_dis = word[VIC_CTRL_NDIS_BIT];
        c.fast_dis = word[VIC_CTRL_FDIS_BIT];
        c.prio_mask = word[VIC_CTRL_PMASK_LSB +: VIC_PRIO_W];
        return c;
    endfunction : ctrl_unpack

    // ************************************************
    // Address decode
    // ************************************************
    wire is_prio = (acc_adr >= VIC_PRIO_OFF) && (acc_adr < VIC_PRIO_END);
    wire [2:0] prio_idx = acc_adr[4:2];
    wire wr_ctrl = wr_stb && acc_adr == VIC_CTRL_OFF;
    wire wr_enlo = wr_stb && acc_adr == VIC_ENLO_OFF;
    wire wr_enhi = wr_stb && acc_adr == VIC_ENHI_OFF;
    wire wr_clslo = wr_stb && acc_adr == VIC_CLSLO_OFF;
    wire wr_clshi = wr_stb && acc_adr == VIC_CLSHI_OFF;
    wire wr_frclo = wr_stb && acc_adr == VIC_FRCLO_OFF;
    wire wr_frchi = wr_stb && acc_adr == VIC_FRCHI_OFF;
    wire wr_imask = wr_stb && acc_adr == VIC_IMASK_OFF;
    wire wr_prio = wr_stb && is_prio;
    wire rd_istat = rd_stb && acc_adr == VIC_ISTAT_OFF;

    wire [31:0] ctrl_word = {24'h0, ctrl_reg.prio_mask, 2'h0, ctrl_reg.fast_dis, ctrl_reg.norm_dis};
    wire [31:0] ctrl_merged = lane_merge(ctrl_word, dat_i, sel_i);
    wire [31:0] prio_word = prio_idx[0] ? prio_reg[prio_idx[2:1]][63:32]
                                        : prio_reg[prio_idx[2:1]][31:0];

    // ************************************************
    // Read mux, unmapped addresses read zero
    // ************************************************
    always_comb
    begin
        rd_data = VIC_RD_NONE;
        case (acc_adr)
            VIC_CTRL_OFF: rd_data = ctrl_word;
            VIC_ENLO_OFF: rd_data = en_reg[31:0];
            VIC_ENHI_OFF: rd_data = en_reg[63:32];
            VIC_CLSLO_OFF: rd_data = cls_reg[31:0];
            VIC_CLSHI_OFF: rd_data = cls_reg[63:32];
            VIC_FRCLO_OFF: rd_data = frc_reg[31:0];
            VIC_FRCHI_OFF: rd_data = frc_reg[63:32];
            VIC_NPLO_OFF: rd_data = npend_reg[31:0];
            VIC_NPHI_OFF: rd_data = npend_reg[63:32];
            VIC_FPLO_OFF: rd_data = fpend_reg[31:0];
            VIC_FPHI_OFF: rd_data = fpend_reg[63:32];
            VIC_VEC_OFF: rd_data = {vec_reg.valid, 21'h0, vec_reg.level, vec_reg.idx};
            VIC_ISTAT_OFF: rd_data = {30'h0, istat_reg};
            VIC_IMASK_OFF: rd_data = {30'h0, imask_reg};
            default:
            begin
                if (is_prio)
                    rd_data = prio_word;
            end
        endcase
    end

    // ************************************************
    // Request qualification
    // ************************************************
    logic [63:0] src_ext;
    logic [63:0] raw;
    logic [63:0] nq;
    logic [63:0] fq;
    logic [63:0] nq_lvl;
    logic [64*VIC_PRIO_W-1:0] prio_flat;

    always_comb
    begin
        src_ext = '0;
        src_ext[NSRC-1:0] = src_i;
        raw = (src_ext | frc_reg) & en_reg;
        nq = raw & ~cls_reg;
        fq = raw & cls_reg;
        for (int i = 0; i < 4; i++)
            prio_flat[i*64 +: 64] = prio_reg[i];
        // Level must exceed the mask level: mask 0 blocks level 0, mask 15 blocks all
        for (int i = 0; i < 64; i++)
            nq_lvl[i] = nq[i] &&
                (prio_flat[i*VIC_PRIO_W +: VIC_PRIO_W] > ctrl_reg.prio_mask);
    end

    vic_pick_t pick;

    vic_prio_pick #(.NSRC(64)) u_pick
    (
        .pend_i(nq_lvl),
        .prio_i(prio_flat),
        .pick_o(pick)
    );

    wire norm_any = |nq_lvl && !ctrl_reg.norm_dis;
    wire fast_any = |fq && !ctrl_reg.fast_dis;
    wire [VIC_EV_W-1:0] ev = {fast_any && !fast_reg, norm_any && !norm_reg};

    // ************************************************
    // Registers
    // ************************************************
    always_comb
    begin
        istat_next = istat_reg;
        // Clear only what the read returned; an event during the read survives
        if (rd_istat)
            istat_next = istat_reg & ~dat_o[VIC_EV_W-1:0];
        istat_next = istat_next | ev; // Set wins over read-clear
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_reg <= ctrl_unpack(VIC_CTRL_RST);
            en_reg <= '0;
            cls_reg <= '0;
            frc_reg <= '0;
            imask_reg <= '0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_reg <= ctrl_unpack(ctrl_merged);
            if (wr_enlo)
                en_reg[31:0] <= lane_merge(en_reg[31:0], dat_i, sel_i);
            if (wr_enhi)
                en_reg[63:32] <= lane_merge(en_reg[63:32], dat_i, sel_i);
            if (wr_clslo)
                cls_reg[31:0] <= lane_merge(cls_reg[31:0], dat_i, sel_i);
            if (wr_clshi)
                cls_reg[63:32] <= lane_merge(cls_reg[63:32], dat_i, sel_i);
            if (wr_frclo)
                frc_reg[31:0] <= lane_merge(frc_reg[31:0], dat_i, sel_i);
            if (wr_frchi)
                frc_reg[63:32] <= lane_merge(frc_reg[63:32], dat_i, sel_i);
            if (wr_imask)
                imask_reg <= dat_i[VIC_EV_W-1:0];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < 4; i++)
                prio_reg[i] <= '0;
        end
        else if (wr_prio)
        begin
            if (prio_idx[0])
                prio_reg[prio_idx[2:1]][63:32] <= lane_merge(prio_word, dat_i, sel_i);
            else
                prio_reg[prio_idx[2:1]][31:0] <= lane_merge(prio_word, dat_i, sel_i);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            npend_reg <= '0;
            fpend_reg <= '0;
            vec_reg <= '0;
            norm_reg <= 1'b0;
            fast_reg <= 1'b0;
            istat_reg <= '0;
        end
        else
        begin
            npend_reg <= nq;
            fpend_reg <= fq;
            vec_reg <= pick;
            norm_reg <= norm_any;
            fast_reg <= fast_any;
            istat_reg <= istat_next;
        end
    end

    assign norm_irq_o = norm_reg;
    assign fast_irq_o = fast_reg;
    assign irq_o = |(istat_reg & imask_reg);

    // ************************************************
    // Checks
    // ************************************************
    a_dis_blocks_norm: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(ctrl_reg.norm_dis) |-> !norm_irq_o)
        else $error("normal request while class disabled");
    a_dis_blocks_fast: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(ctrl_reg.fast_dis) |-> !fast_irq_o)
        else $error("fast request while class disabled");
    a_norm_follows_pend: assert property (@(posedge clk_i) disable iff (rst_i)
        (|nq_lvl && !ctrl_reg.norm_dis) |=> norm_irq_o)
        else $error("normal request missing");
    a_fast_follows_pend: assert property (@(posedge clk_i) disable iff (rst_i)
        (|fq && !ctrl_reg.fast_dis) |=> fast_irq_o)
        else $error("fast request missing");
    a_disabled_silent: assert property (@(posedge clk_i) disable iff (rst_i)
        (en_reg == 64'h0) |=> (npend_reg == 64'h0 && fpend_reg == 64'h0))
        else $error("disabled source shows pending");
    a_class_split: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 (npend_reg & fpend_reg) == 64'h0)
        else $error("source pending in both classes");
    a_vec_level_above: assert property (@(posedge clk_i) disable iff (rst_i)
        pick.valid |-> pick.level > ctrl_reg.prio_mask)
        else $error("vector at or below mask level");
    wire [63:0] frc_want = frc_reg & en_reg & ~cls_reg;
    a_force_pends: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 ((npend_reg & $past(frc_want)) == $past(frc_want)))
        else $error("forced source not pending");
    a_vec_valid_norm: assert property (@(posedge clk_i) disable iff (rst_i)
        vec_reg.valid |-> npend_reg[vec_reg.idx])
        else $error("vector names a source not pending");

    c_norm_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(norm_irq_o));
    c_fast_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(fast_irq_o));
    c_status_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
    c_status_clear: cover property (@(posedge clk_i) disable iff (rst_i)
        rd_istat && istat_reg != '0);

endmodule : vic_top

// file: rtl/vic_wb_slave.sv
// Purpose: Classic Wishbone slave front end for the collector registers
// Assumes: Master holds the request until ack
// Notes: Ack one cycle after the request is seen, dropped the next cycle
`timescale 1ns/1ps
module vic_wb_slave
    import vic_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [VIC_ADDR_W-1:0] adr_i,
    input wire logic [31:0] rd_data_i,
    output logic ack_o,
    output logic [31:0] dat_o,
    output logic wr_stb_o,
    output logic rd_stb_o,
    output logic [VIC_ADDR_W-1:0] acc_adr_o
);

    logic ack_reg;
    logic [31:0] dat_reg;
    wire req = cyc_i && stb_i && !ack_reg;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_reg <= 1'b0;
            dat_reg <= VIC_RD_NONE;
        end
        else
        begin
            ack_reg <= req;
            if (req && !we_i)
                dat_reg <= rd_data_i;
        end
    end

    // Effects happen at the acknowledging edge, exactly once per access
    assign ack_o = ack_reg;
    assign dat_o = dat_reg;
    assign wr_stb_o = ack_reg && we_i;
    assign rd_stb_o = ack_reg && !we_i;
    assign acc_adr_o = adr_i;

endmodule : vic_wb_slave

// file: test/tb.sv
// Purpose: Self-checking bench of the collector through its register bus
// Assumes: Ack comes a cycle after the request; outputs follow sources by one edge
// Notes: Source 5 and 40 share level 3, source 2 is forced at level 5
`timescale 1ns/1ps
module tb;
    import vic_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat_w = 32'h0000_0000;
    logic [63:0] src = 64'h0;
    logic [31:0] dat_o;
    logic ack_o;
    logic norm_irq_o;
    logic fast_irq_o;
    logic irq_o;
    logic [7:0] norm_entry;
    logic [7:0] fast_entry;
    int bad_count = 0;
    int tests_run = 0;

    always #5 clk_i = ~clk_i;

    vic_top #(.NSRC(64)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_o), .ack_o(ack_o),
        .src_i(src), .norm_irq_o(norm_irq_o), .fast_irq_o(fast_irq_o), .irq_o(irq_o));

    vic_core_model core_u (.clk_i(clk_i), .rst_i(rst_i), .norm_irq_i(norm_irq_o),
        .fast_irq_i(fast_irq_o), .norm_entry_o(norm_entry), .fast_entry_o(fast_entry));

    // ************************************************
    // Bus and compare tasks
    // ************************************************
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        sel <= 4'hf;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_o !== 1'b1 && n < 20);
        // A missing ack ends the run rather than hanging it
        if (ack_o !== 1'b1)
        begin
            bad_count++;
            $display("MISMATCH ack expected 1 seen %b", ack_o);
            wrap_up();
        end
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0000_0000, q);
        chk(nm, exp, q);
    endtask : rd

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    task automatic pin(input string nm, input logic exp, input logic got);
        chk(nm, {31'h0, exp}, {31'h0, got});
    endtask : pin

    function automatic logic [31:0] vec(input int idx, input int lvl);
        return {1'b1, 21'h0, 4'(lvl), 6'(idx)};
    endfunction : vec

    // ************************************************
    // Test sequence
    // ************************************************
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rd("ctrl", VIC_CTRL_OFF, VIC_CTRL_RST);
        rd("vector", VIC_VEC_OFF, VIC_RD_NONE);
        rd("unmapped", 8'h3c, 32'h0000_0000);
        pin("norm", 1'b0, norm_irq_o);
        $display("test reset done");

        wr(VIC_PRIO_OFF, 32'h0030_0500);
        wr(8'h54, 32'h0000_0003);
        wr(VIC_ENLO_OFF, 32'h0000_0024);
        wr(VIC_ENHI_OFF, 32'h8000_0100);
        wr(VIC_CLSHI_OFF, 32'h8000_0000);
        src[5] <= 1'b1;
        tick(2);
        pin("norm", 1'b1, norm_irq_o);
        pin("irq masked", 1'b0, irq_o);
        rd("norm pend lo", VIC_NPLO_OFF, 32'h0000_0020);
        rd("vector", VIC_VEC_OFF, vec(5, 3));
        wr(VIC_IMASK_OFF, 32'h0000_0003);
        tick(1);
        pin("irq", 1'b1, irq_o);
        rd("status", VIC_ISTAT_OFF, 32'h0000_0001);
        tick(1);
        pin("irq cleared", 1'b0, irq_o);
        $display("test normal done");

        src[40] <= 1'b1;
        tick(2);
        rd("vector tie", VIC_VEC_OFF, vec(40, 3));
        rd("norm pend hi", VIC_NPHI_OFF, 32'h0000_0100);
        wr(VIC_CTRL_OFF, 32'h0000_0030);
        tick(2);
        pin("norm at mask", 1'b0, norm_irq_o);
        wr(VIC_CTRL_OFF, 32'h0000_0020);
        tick(2);
        pin("norm above mask", 1'b1, norm_irq_o);
        wr(VIC_CTRL_OFF, 32'h0000_0021);
        tick(2);
        pin("norm disabled", 1'b0, norm_irq_o);
        wr(VIC_CTRL_OFF, 32'h0000_0000);
        $display("test priority done");

        wr(VIC_FRCLO_OFF, 32'h0000_0004);
        rd("vector forced", VIC_VEC_OFF, vec(2, 5));
        rd("pend forced", VIC_NPLO_OFF, 32'h0000_0024);
        wr(VIC_FRCLO_OFF, 32'h0000_0000);
        src[7] <= 1'b1;
        wr(VIC_ENLO_OFF, 32'h0000_0004);
        rd("pend off", VIC_NPLO_OFF, 32'h0000_0000);
        rd("vector left", VIC_VEC_OFF, vec(40, 3));
        wr(VIC_ENHI_OFF, 32'h8000_0000);
        tick(2);
        pin("norm none", 1'b0, norm_irq_o);
        $display("test enable done");

        rd("status drain", VIC_ISTAT_OFF, 32'h0000_0001);
        src[63] <= 1'b1;
        tick(2);
        pin("fast", 1'b1, fast_irq_o);
        pin("norm quiet", 1'b0, norm_irq_o);
        rd("fast pend hi", VIC_FPHI_OFF, 32'h8000_0000);
        rd("status fast", VIC_ISTAT_OFF, 32'h0000_0002);
        chk("fast entries", 32'h0000_0001, {24'h0, fast_entry});
        chk("norm entries", 32'h0000_0003, {24'h0, norm_entry});
        wr(VIC_CTRL_OFF, 32'h0000_0002);
        tick(2);
        pin("fast disabled", 1'b0, fast_irq_o);
        $display("test fast done");
        wrap_up();
    end
endmodule : tb

// file: test/vic_core_model.sv
// Purpose: Behavioural stand-in for the processor core that takes the requests
// Assumes: Requests are levels, sampled on the system clock
// Notes: Counts entries into each handler, one per rising request level
`timescale 1ns/1ps
module vic_core_model
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic norm_irq_i,
    input wire logic fast_irq_i,
    output logic [7:0] norm_entry_o,
    output logic [7:0] fast_entry_o
);
    logic norm_seen_reg;
    logic fast_seen_reg;

    // A level held high is one entry; the core only re-enters after a drop
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            norm_seen_reg <= 1'b0;
            fast_seen_reg <= 1'b0;
            norm_entry_o <= 8'h00;
            fast_entry_o <= 8'h00;
        end
        else
        begin
            norm_seen_reg <= norm_irq_i;
            fast_seen_reg <= fast_irq_i;
            if (norm_irq_i && !norm_seen_reg)
                norm_entry_o <= norm_entry_o + 8'h01;
            if (fast_irq_i && !fast_seen_reg)
                fast_entry_o <= fast_entry_o + 8'h01;
        end
    end
endmodule : vic_core_model
